// ==== core/sample_sync_gpio.sv ====
/*
 * Sample and exposure sync controller for the two general-purpose pins.
 * Picks the timing source, the start and abort events for the sample
 * sequencer and the drive of both pins from the function select.
 * Assumes the sequencer reports exposure activity, the current slot
 * code, power-up completion and the fifo push on mclk_i.
 */
`timescale 1ns/10ps
module sample_sync_gpio (
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic [3:0]  func_sel_i,
    input  wire logic [23:0] exposure_slot_code_i,
    input  wire logic [3:0]  active_slot_code_i,
    input  wire logic        exposure_active_i,
    input  wire logic        internal_tick_i,
    input  wire logic        internal_start_i,
    input  wire logic        powerup_done_i,
    input  wire logic        fifo_push_i,
    input  wire logic        sync_pin_one_i,
    input  wire logic        sync_pin_two_i,
    output logic             timing_tick_o,
    output logic             sample_start_o,
    output logic             sample_abort_o,
    output logic             powerup_start_o,
    output logic             sync_pin_one_o,
    output logic             sync_pin_one_oe_n_o,
    output logic             sync_pin_two_o,
    output logic             sync_pin_two_oe_n_o
);
    // ==========================================================
    // pin events
    pin_edge_if edges ();

    pin_edge_finder u_edges (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .pin_i  ({sync_pin_two_i, sync_pin_one_i}),
        .edges  (edges)
    );

    // decoded pin edges and slot decode results
    logic                     one_rise;
    logic                     one_fall;
    logic                     two_rise;
    logic [sync_pkg::SLOT_COUNT-1:0] slot_muxed;
    logic                     any_muxed;
    logic                     code_muxed;

    // the edges that the modes listen to
    assign one_rise = edges.rise[sync_pkg::PIN_ONE];
    assign one_fall = edges.fall[sync_pkg::PIN_ONE];
    assign two_rise = edges.rise[sync_pkg::PIN_TWO];

    // ==========================================================
    // slot codes that ask for the external led mux
    genvar s;
    generate
        for (s = 0; s < sync_pkg::SLOT_COUNT; s++) begin : g_slot
            logic [3:0] code;
            assign code = exposure_slot_code_i[s*sync_pkg::CODE_W +:
                                               sync_pkg::CODE_W];
            assign slot_muxed[s] = (code == sync_pkg::CODE_LED_FOUR) ||
                                   (code == sync_pkg::CODE_LED_FIVE) ||
                                   (code == sync_pkg::CODE_LED_SIX);
        end
    endgenerate

    assign any_muxed  = |slot_muxed;
    // exposure of led four, five or six under way
    assign code_muxed = exposure_active_i &&
                        ((active_slot_code_i == sync_pkg::CODE_LED_FOUR) ||
                         (active_slot_code_i == sync_pkg::CODE_LED_FIVE) ||
                         (active_slot_code_i == sync_pkg::CODE_LED_SIX));

    // ==========================================================
    // timing source selected by the function select
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            timing_tick_o <= sync_pkg::RST_PULSE;
        end else begin
            unique case (func_sel_i)
                sync_pkg::FSEL_SLAVE_EXP:  timing_tick_o <= one_rise;
                sync_pkg::FSEL_MASTER_EXP: timing_tick_o <= two_rise;
                sync_pkg::FSEL_FORCE_SYNC: timing_tick_o <= two_rise;
                sync_pkg::FSEL_SINGLE_SAMPLE_TRIGGER: begin
                    timing_tick_o <= internal_tick_i;
                end
                default:                   timing_tick_o <= internal_tick_i;
            endcase
        end
    end

    // ==========================================================
    // forced resync: abort now, restart on the next pin two edge
    logic resync_pend_ff;

    // pending flag: set by an abort, cleared by the restart edge
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            resync_pend_ff <= sync_pkg::RST_PULSE;
        end else if (func_sel_i != sync_pkg::FSEL_FORCE_SYNC) begin
            resync_pend_ff <= 1'b0;
        end else if (one_rise) begin
            resync_pend_ff <= 1'b1; // new abort wins over the restart
        end else if (two_rise) begin
            resync_pend_ff <= 1'b0;
        end
    end

    // ==========================================================
    // single_sample_trigger sequence: power-up, one sample, then idle
    sync_pkg::shot_state_t shot_ff;
    sync_pkg::shot_state_t nxt_shot;

    // next state of the single_sample_trigger sequence
    always_comb begin
        nxt_shot = shot_ff;
        if (func_sel_i != sync_pkg::FSEL_SINGLE_SAMPLE_TRIGGER) begin
            nxt_shot = sync_pkg::SHOT_IDLE;
        end else begin
            unique case (shot_ff)
                sync_pkg::SHOT_IDLE: begin
                    if (one_fall) begin
                        nxt_shot = sync_pkg::SHOT_POWER;
                    end
                end
                sync_pkg::SHOT_POWER: begin
                    if (powerup_done_i) begin
                        nxt_shot = sync_pkg::SHOT_RUN;
                    end
                end
                sync_pkg::SHOT_RUN: begin
                    if (fifo_push_i) begin
                        nxt_shot = sync_pkg::SHOT_IDLE;
                    end
                end
                default: nxt_shot = sync_pkg::SHOT_IDLE;
            endcase
        end
    end

    // single_sample_trigger state register
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shot_ff <= sync_pkg::SHOT_IDLE;
        end else begin
            shot_ff <= nxt_shot;
        end
    end

    // ==========================================================
    // start, abort and power-up pulses to the sequencer
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sample_start_o  <= sync_pkg::RST_PULSE;
            sample_abort_o  <= sync_pkg::RST_PULSE;
            powerup_start_o <= sync_pkg::RST_PULSE;
        end else begin
            sample_abort_o  <= 1'b0;
            powerup_start_o <= 1'b0;
            unique case (func_sel_i)
                sync_pkg::FSEL_SLAVE_EXP: begin
                    sample_start_o <= one_rise;
                end
                sync_pkg::FSEL_FORCE_SYNC: begin
                    sample_abort_o <= one_rise;
                    sample_start_o <= two_rise && resync_pend_ff &&
                                      !one_rise;
                end
                sync_pkg::FSEL_SINGLE_SAMPLE_TRIGGER: begin
                    powerup_start_o <= (shot_ff == sync_pkg::SHOT_IDLE) &&
                                       one_fall;
                    sample_start_o  <= (shot_ff == sync_pkg::SHOT_POWER) &&
                                       powerup_done_i;
                end
                default: begin
                    sample_start_o <= internal_start_i;
                end
            endcase
        end
    end

    // ==========================================================
    // pin one drive: master exposure output only in 1000
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_pin_one_o      <= sync_pkg::RST_PULSE;
            sync_pin_one_oe_n_o <= sync_pkg::RST_OE_N;
        end else if (func_sel_i == sync_pkg::FSEL_MASTER_EXP) begin
            sync_pin_one_o      <= exposure_active_i;
            sync_pin_one_oe_n_o <= 1'b0;
        end else begin
            sync_pin_one_o      <= 1'b0;
            sync_pin_one_oe_n_o <= 1'b1; // input in every other mode
        end
    end

    // ==========================================================
    // pin two drive: led mux control or float
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_pin_two_o      <= sync_pkg::RST_PIN_OUT;
            sync_pin_two_oe_n_o <= sync_pkg::RST_OE_N;
        end else begin
            unique case (func_sel_i)
                sync_pkg::FSEL_SLAVE_EXP: begin
                    sync_pin_two_o      <= !code_muxed;
                    sync_pin_two_oe_n_o <= !any_muxed;
                end
                sync_pkg::FSEL_SINGLE_SAMPLE_TRIGGER: begin
                    sync_pin_two_o      <= !code_muxed;
                    sync_pin_two_oe_n_o <= !any_muxed;
                end
                default: begin
                    sync_pin_two_o      <= 1'b1;
                    sync_pin_two_oe_n_o <= 1'b1; // clock input or unused
                end
            endcase
        end
    end
endmodule

// ==== core/sync_pkg.sv ====
/*
 * Constants for the sample and exposure sync logic of the two
 * general-purpose pins: function-select codes, slot codes, reset values.
 * Assumes it is compiled before every other file of the block.
 */
package sync_pkg;
    // ==========================================================
    // function-select codes
    localparam logic [3:0] FSEL_SLAVE_EXP  = 4'h6;
    localparam logic [3:0] FSEL_MASTER_EXP = 4'h8;
    localparam logic [3:0] FSEL_FORCE_SYNC = 4'h9;
    localparam logic [3:0] FSEL_SINGLE_SAMPLE_TRIGGER   = 4'hA;
    // ==========================================================
    // exposure slot codes that select a muxed led
    localparam int         SLOT_COUNT      = 6;
    localparam int         CODE_W          = 4;
    localparam logic [3:0] CODE_LED_FOUR   = 4'hA;
    localparam logic [3:0] CODE_LED_FIVE   = 4'hB;
    localparam logic [3:0] CODE_LED_SIX    = 4'hC;
    // ==========================================================
    // pin positions and reset values
    localparam int         PIN_ONE         = 0;
    localparam int         PIN_TWO         = 1;
    localparam logic       RST_PULSE       = 1'b0;
    localparam logic       RST_PIN_OUT     = 1'b1;
    localparam logic       RST_OE_N        = 1'b1;
    localparam logic [1:0] RST_SYNC        = 2'h0;
    // edges after reset until the sync chain holds the pin level
    localparam logic [1:0] SYNC_FILL       = 2'h3;
    // ==========================================================
    // single_sample_trigger sequence states, gray from idle through power to run
    typedef enum logic [1:0] {
        SHOT_IDLE  = 2'b00,
        SHOT_POWER = 2'b01,
        SHOT_RUN   = 2'b11
    } shot_state_t;
endpackage

// ==== core/pin_edge_if.sv ====
/*
 * Carrier for synchronised pin events between the edge finder and the
 * sync controller. Assumes both ends share mclk_i.
 */
`timescale 1ns/10ps
interface pin_edge_if;
    logic [1:0] rise;
    logic [1:0] fall;
    modport src (output rise, output fall);
    modport dst (input  rise, input  fall);
endinterface

// ==== core/pin_edge_finder.sv ====
/*
 * Two-flop synchronisers and edge finders for both sync pins.
 * Assumes the pins are asynchronous to mclk_i and slower than it.
 */
`timescale 1ns/10ps
module pin_edge_finder (
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    input  wire logic [1:0] pin_i,
    pin_edge_if.src         edges
);
    // ==========================================================
    // hold edges off until both sync stages and the history stage
    // carry the real pin level, so a pin idling high after reset
    // gives no false edge
    logic [1:0] fill_ff;
    logic       armed;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fill_ff <= sync_pkg::RST_SYNC;
        end else if (fill_ff != sync_pkg::SYNC_FILL) begin
            fill_ff <= fill_ff + 2'h1;
        end
    end

    assign armed = (fill_ff == sync_pkg::SYNC_FILL);

    // ==========================================================
    // per pin: two sync stages, one history stage
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            logic meta_ff;
            logic sync_ff;
            logic last_ff;
            // first stage is read only by the second
            always_ff @(posedge mclk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                    last_ff <= 1'b0;
                end else begin
                    meta_ff <= pin_i[g];
                    sync_ff <= meta_ff;
                    last_ff <= sync_ff;
                end
            end
            // one pulse per settled edge
            assign edges.rise[g] = armed & sync_ff & ~last_ff;
            assign edges.fall[g] = armed & ~sync_ff & last_ff;
        end
    endgenerate
endmodule

// ==== test/sync_partner.sv ====
/*
 * Far-side model: trigger source on pin one, 1.25 MHz source on pin two.
 * Assumes the bench resolves nothing else; pin two has a pull-up.
 */
`timescale 1ns/10ps
module sync_partner (
    input  wire logic trig_i,
    input  wire logic clk_en_i,
    input  wire logic dut_one_i,
    input  wire logic dut_one_oe_n_i,
    input  wire logic dut_two_i,
    input  wire logic dut_two_oe_n_i,
    output logic      pin_one_o,
    output logic      pin_two_o
);
    // ==========================================================
    // link clock, free phase against mclk_i
    logic lclk = 1'b0;
    // slow stand-in for the external clock, gated to frames below
    initial begin
        #137;
        forever #400 lclk = ~lclk;
    end
    // resolved wires: device drive wins, else source or pull-up
    assign pin_one_o = !dut_one_oe_n_i ? dut_one_i : trig_i;
    assign pin_two_o = !dut_two_oe_n_i ? dut_two_i :
                       (clk_en_i ? lclk : 1'b1);
endmodule

// ==== test/sample_sync_gpio_monitor.sv ====
/*
 * Port checker for the sync pin controller.
 * Assumes one clock domain and an active-low asynchronous reset.
 */
`timescale 1ns/10ps
module sample_sync_gpio_monitor (
    input wire logic        mclk_i,
    input wire logic        rstn_i,
    input wire logic [3:0]  func_sel_i,
    input wire logic [23:0] exposure_slot_code_i,
    input wire logic [3:0]  active_slot_code_i,
    input wire logic        exposure_active_i,
    input wire logic        sample_abort_o,
    input wire logic        powerup_start_o,
    input wire logic        timing_tick_o,
    input wire logic        sync_pin_one_o,
    input wire logic        sync_pin_one_oe_n_o,
    input wire logic        sync_pin_two_o,
    input wire logic        sync_pin_two_oe_n_o
);
    // ==========================================================
    // helpers
    logic any_mux;
    logic mux_mode;
    // any slot holding a muxed led code
    always_comb begin
        any_mux = 1'b0;
        for (int s = 0; s < 6; s++) begin
            any_mux |= exposure_slot_code_i[4*s +: 4] inside
                       {4'hA, 4'hB, 4'hC};
        end
    end
    assign mux_mode = func_sel_i inside {4'h6, 4'hA};
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // ==========================================================
    // assertions
    AST_PIN1_OE: assert property (
        func_sel_i == 4'h8 |=> !sync_pin_one_oe_n_o)
        else $error("pin one not driven in master mode");
    AST_PIN1_DRV: assert property (
        func_sel_i == 4'h8 |=>
        sync_pin_one_o == $past(exposure_active_i))
        else $error("pin one does not follow exposure");
    AST_PIN1_IN: assert property (
        func_sel_i == 4'h6 |=> sync_pin_one_oe_n_o)
        else $error("pin one driven in slave mode");
    AST_PIN2_FLOAT: assert property (
        mux_mode && !any_mux |=> sync_pin_two_oe_n_o)
        else $error("pin two driven without mux code");
    AST_PIN2_LOW: assert property (
        mux_mode && any_mux && exposure_active_i &&
        active_slot_code_i inside {4'hA, 4'hB, 4'hC}
        |=> !sync_pin_two_o && !sync_pin_two_oe_n_o)
        else $error("pin two not low on muxed exposure");
    AST_PIN2_HIGH: assert property (
        mux_mode && any_mux && !exposure_active_i
        |=> sync_pin_two_o && !sync_pin_two_oe_n_o)
        else $error("pin two not high between exposures");
    AST_ABORT_MODE: assert property (
        sample_abort_o |-> $past(func_sel_i) == 4'h9)
        else $error("abort outside resync mode");
    AST_ABORT_ONE: assert property (
        sample_abort_o |=> !sample_abort_o)
        else $error("abort longer than one cycle");
    AST_PWR_MODE: assert property (
        powerup_start_o |-> $past(func_sel_i) == 4'hA)
        else $error("power-up outside single_sample_trigger mode");
    AST_PWR_ONE: assert property (
        powerup_start_o |=> (!powerup_start_o)[*8])
        else $error("power-up restarted while busy");
    COV_ABORT: cover property (sample_abort_o);
    COV_PWR: cover property (powerup_start_o);
    COV_MASTER: cover property (func_sel_i == 4'h8 && timing_tick_o);
endmodule

bind sample_sync_gpio sample_sync_gpio_monitor mon (.mclk_i, .rstn_i,
    .func_sel_i, .exposure_slot_code_i, .active_slot_code_i,
    .exposure_active_i, .sample_abort_o, .powerup_start_o, .timing_tick_o,
    .sync_pin_one_o, .sync_pin_one_oe_n_o, .sync_pin_two_o,
    .sync_pin_two_oe_n_o);

// ==== test/tb_sample_sync_gpio.sv ====
/*
 * Self-checking bench for the sync pin controller, one task a mode.
 * Assumes the partner model resolves both pin wires.
 */
`timescale 1ns/10ps
module tb_sample_sync_gpio;
    // ==========================================================
    // signals
    logic        mclk_i = 1'b0, rstn_i = 1'b0, trig = 1'b0, clk_en = 1'b0;
    logic [3:0]  func_sel_i = 4'h0, active_slot_code_i = 4'h0;
    logic [23:0] exposure_slot_code_i = 24'h000000;
    logic        exposure_active_i = 1'b0, powerup_done_i = 1'b0;
    logic        fifo_push_i = 1'b0, pin1_w, pin2_w;
    logic        int_tick = 1'b0;
    logic        timing_tick_o, sample_start_o, sample_abort_o;
    logic        powerup_start_o, sync_pin_one_o, sync_pin_one_oe_n_o;
    logic        sync_pin_two_o, sync_pin_two_oe_n_o;
    int          errors = 0, n_checks = 0;
    // 10 MHz clock
    always #50 mclk_i = ~mclk_i;
    sample_sync_gpio DUT (.mclk_i, .rstn_i, .func_sel_i,
        .exposure_slot_code_i, .active_slot_code_i, .exposure_active_i,
        .internal_tick_i(int_tick), .internal_start_i(1'b0), .powerup_done_i,
        .fifo_push_i, .sync_pin_one_i(pin1_w), .sync_pin_two_i(pin2_w),
        .timing_tick_o, .sample_start_o, .sample_abort_o, .powerup_start_o,
        .sync_pin_one_o, .sync_pin_one_oe_n_o, .sync_pin_two_o,
        .sync_pin_two_oe_n_o);
    sync_partner far (.trig_i(trig), .clk_en_i(clk_en),
        .dut_one_i(sync_pin_one_o), .dut_one_oe_n_i(sync_pin_one_oe_n_o),
        .dut_two_i(sync_pin_two_o), .dut_two_oe_n_i(sync_pin_two_oe_n_o),
        .pin_one_o(pin1_w), .pin_two_o(pin2_w));
    // ==========================================================
    // shared tasks
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [1:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: pick = sample_start_o;
            1: pick = sample_abort_o;
            2: pick = powerup_start_o;
            default: pick = timing_tick_o;
        endcase
    endfunction
    // bounded wait for a pulse output
    task automatic wait_o(input int k);
        int n;
        n = 0;
        #1; // look once the launching edge has settled
        while (pick(k) !== 1'b1) begin
            @(posedge mclk_i);
            #1;
            n++;
            if (n > 200) begin
                errors++;
                end_of_test();
            end
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // ==========================================================
    // scenarios
    task automatic sc_resync();
        @(posedge mclk_i);
        func_sel_i <= 4'h9;
        trig <= 1'b1;
        wait_o(1);
        tick(1);
        check("abort", sample_abort_o, 1'b0);
        check("early start", sample_start_o, 1'b0);
        @(posedge mclk_i);
        clk_en <= 1'b1;
        wait_o(0);
        check("restart tick", timing_tick_o, 1'b1);
        @(posedge mclk_i);
        clk_en <= 1'b0;
    endtask
    task automatic sc_single_sample_trigger();
        @(posedge mclk_i);
        func_sel_i <= 4'hA;
        tick(4);
        check("pin2 float", {sync_pin_two_oe_n_o, pin2_w}, 2'b11);
        @(posedge mclk_i);
        int_tick <= 1'b1;
        @(posedge mclk_i);
        int_tick <= 1'b0;
        tick(0);
        check("internal tick", timing_tick_o, 1'b1);
        repeat (2) begin
            @(posedge mclk_i);
            trig <= 1'b0;
            wait_o(2);
            @(posedge mclk_i);
            powerup_done_i <= 1'b1;
            @(posedge mclk_i);
            powerup_done_i <= 1'b0;
            wait_o(0);
            @(posedge mclk_i);
            fifo_push_i <= 1'b1;
            trig <= 1'b1;
            @(posedge mclk_i);
            fifo_push_i <= 1'b0;
            powerup_done_i <= 1'b1;
            @(posedge mclk_i);
            powerup_done_i <= 1'b0;
            tick(0);
            check("idle start", sample_start_o, 1'b0);
            tick(4);
        end
        @(posedge mclk_i);
        exposure_slot_code_i <= 24'h0CBA00;
        exposure_active_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk_i);
            active_slot_code_i <= (i < 3) ? 4'hA + 4'(i) : 4'h1;
            tick(2);
            check("pin2 mux", {sync_pin_two_oe_n_o, pin2_w},
                  {1'b0, i == 3});
        end
    endtask
    task automatic sc_slave();
        @(posedge mclk_i);
        func_sel_i <= 4'h6;
        exposure_slot_code_i <= 24'h000000;
        trig <= 1'b0;
        tick(4);
        @(posedge mclk_i);
        trig <= 1'b1;
        wait_o(0);
        check("slave tick", timing_tick_o, 1'b1);
        check("pin1 input", sync_pin_one_oe_n_o, 1'b1);
        check("pin2 pulled", {sync_pin_two_oe_n_o, pin2_w}, 2'b11);
        @(posedge mclk_i);
        exposure_slot_code_i <= 24'hB00000;
        active_slot_code_i <= 4'hB;
        tick(2);
        check("pin2 mux", {sync_pin_two_oe_n_o, pin2_w}, 2'b00);
        @(posedge mclk_i);
        exposure_active_i <= 1'b0;
        tick(2);
        check("pin2 gap", {sync_pin_two_oe_n_o, pin2_w}, 2'b01);
    endtask
    task automatic sc_master();
        @(posedge mclk_i);
        func_sel_i <= 4'h8;
        exposure_active_i <= 1'b1;
        tick(3);
        check("pin1 drive", {sync_pin_one_oe_n_o, pin1_w}, 2'b01);
        @(posedge mclk_i);
        clk_en <= 1'b1;
        wait_o(3);
        @(posedge mclk_i);
        exposure_active_i <= 1'b0;
        clk_en <= 1'b0;
        tick(2);
        check("pin1 idle", pin1_w, 1'b0);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge mclk_i);
        rstn_i <= 1'b1;
        tick(4);
        sc_resync();
        sc_single_sample_trigger();
        sc_slave();
        sc_master();
        end_of_test();
    end
endmodule
